// *** design/amss_params.svh ***
// constants of the analog monitor select and scale block
`ifndef AMSS_PARAMS_SVH
`define AMSS_PARAMS_SVH

// selector codes
`define AMSS_SEL_SPEED      4'h0
`define AMSS_SEL_SPD_REF    4'h1
`define AMSS_SEL_TRQ_REF    4'h2
`define AMSS_SEL_POS_ERR    4'h3
`define AMSS_SEL_AMP_ERR    4'h4
`define AMSS_SEL_PREF_SPD   4'h5
`define AMSS_SEL_RESERVED   4'h6
`define AMSS_SEL_LOAD_ERR   4'h7
`define AMSS_SEL_POS_DONE   4'h8
`define AMSS_SEL_SPD_FF     4'h9
`define AMSS_SEL_TRQ_FF     4'hA
`define AMSS_SEL_GAIN_SET   4'hB
`define AMSS_SEL_REF_DONE   4'hC
`define AMSS_SEL_EXT_SPD    4'hD

// register word indices
`define AMSS_REG_SEL        4'h0
`define AMSS_REG_OFS1       4'h1
`define AMSS_REG_OFS2       4'h2
`define AMSS_REG_GAIN1      4'h3
`define AMSS_REG_GAIN2      4'h4
`define AMSS_REG_CODES      4'h5
`define AMSS_REG_STATUS     4'h6

// field positions in the selector word
`define AMSS_SEL1_LSB       0
`define AMSS_SEL2_LSB       8

// reset values
`define AMSS_SEL1_RST       4'h2
`define AMSS_SEL2_RST       4'h0
`define AMSS_GAIN_RST       16'h0064
`define AMSS_OFS_RST        16'h0000

// parameter range, +-10000
`define AMSS_PAR_MAX        16'h2710
`define AMSS_PAR_MIN        16'hD8F0

// microvolts per input unit, then fixed 5 V, 2 V and 1 V levels in microvolts
`define AMSS_K_SPEED        32'h0000_03E8
`define AMSS_K_TORQUE       32'h0000_0064
`define AMSS_K_POS_ERR      32'h0000_C350
`define AMSS_K_LOAD_ERR     32'h0000_2710
`define AMSS_UV_5V          32'h004C_4B40
`define AMSS_UV_2V          32'h001E_8480
`define AMSS_UV_1V          32'h000F_4240

// gain in hundredths, offset in 0.1 V steps
`define AMSS_GAIN_DIV       32'h0000_0064
`define AMSS_OFS_STEP_UV    32'h0001_86A0

// converter: code = uV * 2 / 625 (3200 codes per volt)
`define AMSS_CODE_NUM       32'h0000_0002
`define AMSS_CODE_DEN       32'h0000_0271
`define AMSS_CODE_MAX       16'h7FFF
`define AMSS_LIN_MAX        16'h6400

`endif

// *** design/amss_pkg.sv ***
// types shared by the analog monitor select and scale block
package amss_pkg;
    typedef logic [3:0]          amss_sel_t;
    typedef logic signed [47:0]  amss_uv_t;
    typedef logic signed [15:0]  amss_par_t;
endpackage

// *** design/amss_scale.sv ***
// one monitor channel: multiplier, offset, negation and converter code
`timescale 1ns/1ps
`default_nettype none
`include "amss_params.svh"

module amss_scale
    import amss_pkg::*;
(
    input  wire logic      core_clk_in,
    input  wire logic      rst_n_in,
    input  wire amss_uv_t  raw_uv_in,
    input  wire amss_par_t gain_in,
    input  wire amss_par_t ofs_in,
    output logic [15:0]    code_out,
    output logic           lin_ok_out
);

    logic signed [63:0] prod_q;
    logic signed [63:0] sum_q;
    logic signed [63:0] conv;
    logic signed [63:0] code_max;
    logic signed [63:0] lin_max;

    assign code_max = $signed(64'(`AMSS_CODE_MAX));
    assign lin_max  = $signed(64'(`AMSS_LIN_MAX));

    // ------------------------------------------------------------
    // arithmetic pipeline
    // ------------------------------------------------------------
    // product in hundredths; 64 bits so no setting can overflow
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            prod_q <= '0;
        else
            prod_q <= 64'(raw_uv_in) * 64'(gain_in);
    end

    // output = -(signal * gain + offset), in microvolts
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            sum_q <= '0;
        else
            sum_q <= -((prod_q / $signed(64'(`AMSS_GAIN_DIV)))
                     + 64'(ofs_in) * $signed(64'(`AMSS_OFS_STEP_UV)));
    end

    // microvolts to converter codes
    assign conv = (sum_q * $signed(64'(`AMSS_CODE_NUM))) / $signed(64'(`AMSS_CODE_DEN));

    // saturate rather than wrap: a wrapped code would flip the trace sign
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            code_out   <= '0;
            lin_ok_out <= 1'b1;
        end
        else
        begin
            if (conv > code_max)
                code_out <= `AMSS_CODE_MAX;
            else if (conv < -code_max - 64'sd1)
                code_out <= ~`AMSS_CODE_MAX;
            else
                code_out <= conv[15:0];
            lin_ok_out <= (conv <= lin_max) && (conv >= -lin_max);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_sat_high: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (conv > code_max) |=> (code_out == `AMSS_CODE_MAX))
        else $error("high saturation missed");
    a_sat_low: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (conv < -code_max - 64'sd1) |=> (code_out == ~`AMSS_CODE_MAX))
        else $error("low saturation missed");
    a_output_negated: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (prod_q == 64'sd0) && (ofs_in > 16'sd0) |=> (sum_q < 64'sd0))
        else $error("offset not negated");

endmodule

`default_nettype wire

// *** design/amss_top.sv ***
// analog monitor select and scale: two monitor channels behind Avalon-MM
`timescale 1ns/1ps
`default_nettype none
`include "amss_params.svh"

module amss_top
    import amss_pkg::*;
(
    input  wire logic               core_clk_in,
    input  wire logic               rst_n_in,
    // Avalon-MM slave, word addressed
    input  wire logic [3:0]         avs_address_in,
    input  wire logic               avs_read_in,
    input  wire logic               avs_write_in,
    input  wire logic [31:0]        avs_writedata_in,
    input  wire logic [3:0]         avs_byteenable_in,
    output logic [31:0]             avs_readdata_out,
    output logic                    avs_waitrequest_out,
    // monitored quantities from the servo loops
    input  wire logic signed [31:0] motor_speed_in,
    input  wire logic signed [31:0] speed_ref_in,
    input  wire logic signed [31:0] pos_ref_speed_in,
    input  wire logic signed [31:0] speed_ff_in,
    input  wire logic signed [31:0] ext_enc_speed_in,
    input  wire logic signed [31:0] torque_ref_in,
    input  wire logic signed [31:0] torque_ff_in,
    input  wire logic signed [31:0] pos_err_in,
    input  wire logic signed [31:0] pos_amp_err_in,
    input  wire logic signed [31:0] load_pos_err_in,
    input  wire logic               pos_done_in,
    input  wire logic               ref_done_in,
    input  wire logic               gain2_active_in,
    input  wire logic               pos_mode_in,
    // converter codes for the monitor connector
    output logic [15:0]             monitor1_code_out,
    output logic [15:0]             monitor2_code_out
);

    amss_sel_t   sel_q [2];
    amss_par_t   gain_q [2];
    amss_par_t   ofs_q [2];
    amss_uv_t    raw_q [2];
    logic [15:0] code [2];
    logic        lin_ok [2];
    logic        wait_q;
    logic        req;
    logic        rd_acc;
    logic        wr_acc;
    logic [31:0] rd_word;

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // signed input times an unsigned scale constant, in microvolts
    function automatic amss_uv_t amss_mul(input logic signed [31:0] v,
                                          input logic [31:0]        k);
        return 48'(v) * $signed(48'(k));
    endfunction

    // apply byte enables to a register word
    function automatic logic [31:0] amss_merge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                r[i*8 +: 8] = wd[i*8 +: 8];
        end
        return r;
    endfunction

    // clamp a written value into the +-10000 setting range
    function automatic amss_par_t amss_clamp(input logic signed [31:0] v);
        // signed compare: a negative write must not be clamped to the top
        if (v > $signed(32'(`AMSS_PAR_MAX)))
            return `AMSS_PAR_MAX;
        else if (v < $signed(32'(-$signed(`AMSS_PAR_MAX))))
            return `AMSS_PAR_MIN;
        else
            return v[15:0];
    endfunction

    // selector decode, used by both channels
    function automatic amss_uv_t amss_pick(input amss_sel_t s);
        case (s)
            `AMSS_SEL_SPEED:    return amss_mul(motor_speed_in, `AMSS_K_SPEED);
            `AMSS_SEL_SPD_REF:  return amss_mul(speed_ref_in, `AMSS_K_SPEED);
            `AMSS_SEL_PREF_SPD: return amss_mul(pos_ref_speed_in, `AMSS_K_SPEED);
            `AMSS_SEL_SPD_FF:   return amss_mul(speed_ff_in, `AMSS_K_SPEED);
            `AMSS_SEL_EXT_SPD:  return amss_mul(ext_enc_speed_in, `AMSS_K_SPEED);
            `AMSS_SEL_TRQ_REF:  return amss_mul(torque_ref_in, `AMSS_K_TORQUE);
            `AMSS_SEL_TRQ_FF:   return amss_mul(torque_ff_in, `AMSS_K_TORQUE);
            `AMSS_SEL_POS_ERR:  return pos_mode_in ?
                                       amss_mul(pos_err_in, `AMSS_K_POS_ERR) : '0;
            `AMSS_SEL_AMP_ERR:  return amss_mul(pos_amp_err_in, `AMSS_K_POS_ERR);
            `AMSS_SEL_LOAD_ERR: return amss_mul(load_pos_err_in, `AMSS_K_LOAD_ERR);
            `AMSS_SEL_POS_DONE: return pos_done_in ? 48'(`AMSS_UV_5V) : '0;
            `AMSS_SEL_GAIN_SET: return gain2_active_in ? 48'(`AMSS_UV_2V)
                                                       : 48'(`AMSS_UV_1V);
            `AMSS_SEL_REF_DONE: return ref_done_in ? 48'(`AMSS_UV_5V) : '0;
            // reserved code 06 and unused codes give a quiet 0 V
            default:            return '0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    assign req    = avs_read_in || avs_write_in;
    assign rd_acc = avs_read_in && !wait_q;
    assign wr_acc = avs_write_in && !wait_q;

    // waitrequest drops for one cycle per request; the extra cycle
    // lets read data come from a register
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            wait_q <= 1'b1;
        else
            wait_q <= !(req && wait_q);
    end

    // read mux; unmapped words read as zero
    always_comb
    begin
        rd_word = '0;
        case (avs_address_in)
            `AMSS_REG_SEL:    rd_word = {20'h0_0000, sel_q[1], 4'h0, sel_q[0]};
            `AMSS_REG_OFS1:   rd_word = 32'(ofs_q[0]);
            `AMSS_REG_OFS2:   rd_word = 32'(ofs_q[1]);
            `AMSS_REG_GAIN1:  rd_word = 32'(gain_q[0]);
            `AMSS_REG_GAIN2:  rd_word = 32'(gain_q[1]);
            `AMSS_REG_CODES:  rd_word = {monitor2_code_out, monitor1_code_out};
            `AMSS_REG_STATUS: rd_word = {30'h0000_0000, lin_ok[1], lin_ok[0]};
            default:          rd_word = '0;
        endcase
    end

    // read data captured while waitrequest is still high
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            avs_readdata_out <= '0;
        else if (avs_read_in && wait_q)
            avs_readdata_out <= rd_word;
    end

    assign avs_waitrequest_out = wait_q;

    // ------------------------------------------------------------
    // setting registers
    // ------------------------------------------------------------
    // selectors; a write takes effect at the accepting edge
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sel_q[0] <= `AMSS_SEL1_RST;
            sel_q[1] <= `AMSS_SEL2_RST;
        end
        else if (wr_acc && avs_address_in == `AMSS_REG_SEL)
        begin
            if (avs_byteenable_in[0])
                sel_q[0] <= avs_writedata_in[`AMSS_SEL1_LSB +: 4];
            if (avs_byteenable_in[1])
                sel_q[1] <= avs_writedata_in[`AMSS_SEL2_LSB +: 4];
        end
    end

    // offsets and gains, clamped, active at once
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ofs_q[0]  <= `AMSS_OFS_RST;
            ofs_q[1]  <= `AMSS_OFS_RST;
            gain_q[0] <= `AMSS_GAIN_RST;
            gain_q[1] <= `AMSS_GAIN_RST;
        end
        else if (wr_acc)
        begin
            case (avs_address_in)
                `AMSS_REG_OFS1:  ofs_q[0]  <= amss_clamp(amss_merge(32'(ofs_q[0]),
                                     avs_writedata_in, avs_byteenable_in));
                `AMSS_REG_OFS2:  ofs_q[1]  <= amss_clamp(amss_merge(32'(ofs_q[1]),
                                     avs_writedata_in, avs_byteenable_in));
                `AMSS_REG_GAIN1: gain_q[0] <= amss_clamp(amss_merge(32'(gain_q[0]),
                                     avs_writedata_in, avs_byteenable_in));
                `AMSS_REG_GAIN2: gain_q[1] <= amss_clamp(amss_merge(32'(gain_q[1]),
                                     avs_writedata_in, avs_byteenable_in));
                default:         ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    generate
        for (genvar ch = 0; ch < 2; ch++)
        begin : g_ch
            // selected quantity in microvolts, registered
            always_ff @(posedge core_clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                    raw_q[ch] <= '0;
                else
                    raw_q[ch] <= amss_pick(sel_q[ch]);
            end

            amss_scale u_scale
            (
                .core_clk_in (core_clk_in),
                .rst_n_in    (rst_n_in),
                .raw_uv_in   (raw_q[ch]),
                .gain_in     (gain_q[ch]),
                .ofs_in      (ofs_q[ch]),
                .code_out    (code[ch]),
                .lin_ok_out  (lin_ok[ch])
            );

            a_speed_scale: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
                (sel_q[ch] == `AMSS_SEL_SPEED)
                |=> (raw_q[ch] == amss_mul($past(motor_speed_in), `AMSS_K_SPEED)))
                else $error("motor speed scale wrong");
            a_ext_speed: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
                (sel_q[ch] == `AMSS_SEL_EXT_SPD)
                |=> (raw_q[ch] == amss_mul($past(ext_enc_speed_in), `AMSS_K_SPEED)))
                else $error("external speed scale wrong");
            a_pos_err_mode: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
                (sel_q[ch] == `AMSS_SEL_POS_ERR && !pos_mode_in) |=> (raw_q[ch] == '0))
                else $error("position error not zero outside position mode");
            a_amp_err: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
                (sel_q[ch] == `AMSS_SEL_AMP_ERR)
                |=> (raw_q[ch] == amss_mul($past(pos_amp_err_in), `AMSS_K_POS_ERR)))
                else $error("amplifier error scale wrong");
            a_load_err: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
                (sel_q[ch] == `AMSS_SEL_LOAD_ERR)
                |=> (raw_q[ch] == amss_mul($past(load_pos_err_in), `AMSS_K_LOAD_ERR)))
                else $error("load error scale wrong");
            a_pos_done: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
                (sel_q[ch] == `AMSS_SEL_POS_DONE)
                |=> (raw_q[ch] == ($past(pos_done_in) ? 48'(`AMSS_UV_5V) : 48'sd0)))
                else $error("positioning done level wrong");
            a_gain_set: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
                (sel_q[ch] == `AMSS_SEL_GAIN_SET && gain2_active_in)
                |=> (raw_q[ch] == 48'(`AMSS_UV_2V)))
                else $error("second gain level wrong");
            a_ref_done: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
                (sel_q[ch] == `AMSS_SEL_REF_DONE && !ref_done_in) |=> (raw_q[ch] == '0))
                else $error("reference done level wrong");
            a_torque_scale: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
                (sel_q[ch] == `AMSS_SEL_TRQ_REF)
                |=> (raw_q[ch] == amss_mul($past(torque_ref_in), `AMSS_K_TORQUE)))
                else $error("torque scale wrong");
            a_setting_range: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
                (ofs_q[ch] <= $signed(`AMSS_PAR_MAX)) && (ofs_q[ch] >= $signed(`AMSS_PAR_MIN))
                && (gain_q[ch] <= $signed(`AMSS_PAR_MAX))
                && (gain_q[ch] >= $signed(`AMSS_PAR_MIN)))
                else $error("setting outside range");
        end
    endgenerate

    // codes leave through a flop so the connector sees clean steps
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            monitor1_code_out <= '0;
            monitor2_code_out <= '0;
        end
        else
        begin
            monitor1_code_out <= code[0];
            monitor2_code_out <= code[1];
        end
    end

    a_bus_answer: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (req && wait_q) |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("bus answer timing wrong");

endmodule

`default_nettype wire

// *** bench/amss_recorder.sv ***
// partner model: a recorder sampling both monitor channel codes
`timescale 1ns/1ps
`default_nettype none

module amss_recorder
(
    input  wire logic        core_clk_in,
    input  wire logic [15:0] ch1_code_in,
    input  wire logic [15:0] ch2_code_in,
    output logic [15:0]      ch1_seen_out,
    output logic [15:0]      ch2_seen_out
);
    // ------------------------------------------------
    // sampling
    // ------------------------------------------------
    // the instrument only listens; one cycle late, so checks wait past it
    always_ff @(posedge core_clk_in)
    begin
        ch1_seen_out <= ch1_code_in;
        ch2_seen_out <= ch2_code_in;
    end
endmodule

`default_nettype wire

// *** bench/tb_analog_monitor_select_scale.sv ***
// self-checking bench for the analog monitor select and scale block
`timescale 1ns/1ps
`default_nettype none
`include "amss_params.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module tb_analog_monitor_select_scale;
    logic               clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               rd = 1'b0;
    logic               wr = 1'b0;
    logic [3:0]         addr = 4'h0;
    logic [31:0]        wdata = 32'h0000_0000;
    logic [31:0]        rdata;
    logic               wait_o;
    logic signed [31:0] q [10];
    logic               pos_done = 1'b1;
    logic               ref_done = 1'b0;
    logic               gain2 = 1'b1;
    logic               pos_mode = 1'b1;
    logic [15:0]        code1, code2, seen1, seen2;
    int                 error_cnt = 0;
    int                 checks_done = 0;
    int                 cyc = 0;

    amss_top dut (.core_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_o),
        .motor_speed_in(q[0]), .speed_ref_in(q[1]), .pos_ref_speed_in(q[2]),
        .speed_ff_in(q[3]), .ext_enc_speed_in(q[4]), .torque_ref_in(q[5]),
        .torque_ff_in(q[6]), .pos_err_in(q[7]), .pos_amp_err_in(q[8]),
        .load_pos_err_in(q[9]), .pos_done_in(pos_done), .ref_done_in(ref_done),
        .gain2_active_in(gain2), .pos_mode_in(pos_mode),
        .monitor1_code_out(code1), .monitor2_code_out(code2));

    amss_recorder rec (.core_clk_in(clk), .ch1_code_in(code1), .ch2_code_in(code2),
        .ch1_seen_out(seen1), .ch2_seen_out(seen2));

    // ------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------
    initial
    begin
        forever #2.5 clk = ~clk;
    end

    // a run of 32 accesses needs far fewer cycles than this
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            stop_test();
        end
    end

    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    task automatic stop_test;
        $display("checks=%0d errors=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // one access; held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wait_o !== 1'b0);
        r = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    // selected quantity in microvolts before multiplier and offset
    function automatic longint sig_uv(input logic [3:0] s);
        case (s)
            4'h0: return longint'(q[0]) * 1000;
            4'h1: return longint'(q[1]) * 1000;
            4'h5: return longint'(q[2]) * 1000;
            4'h9: return longint'(q[3]) * 1000;
            4'hD: return longint'(q[4]) * 1000;
            4'h2: return longint'(q[5]) * 100;
            4'hA: return longint'(q[6]) * 100;
            4'h3: return pos_mode ? longint'(q[7]) * 50000 : 0;
            4'h4: return longint'(q[8]) * 50000;
            4'h7: return longint'(q[9]) * 10000;
            4'h8: return pos_done ? 5000000 : 0;
            4'hB: return gain2 ? 2000000 : 1000000;
            4'hC: return ref_done ? 5000000 : 0;
            default: return 0;
        endcase
    endfunction

    // negate, scale to 3200 codes per volt, clip at the converter limits
    function automatic logic [15:0] exp_code(input longint uv, input longint g,
                                             input longint o);
        longint v;
        v = -(uv * g / 100 + o * 100000) * 2 / 625;
        if (v > 32767)
            v = 32767;
        if (v < -32768)
            v = -32768;
        return v[15:0];
    endfunction

    task automatic chk_sel(input logic [3:0] s);
        logic [31:0] r;
        bus(1'b1, `AMSS_REG_SEL, {20'h0_0000, s, 4'h0, s}, r);
        repeat (7) @(posedge clk);
        `CHK(seen1, exp_code(sig_uv(s), 100, 0))
        `CHK(seen2, exp_code(sig_uv(s), 100, 0))
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_reset;
        logic [31:0] r;
        repeat (8) @(posedge clk);
        `CHK(seen1, exp_code(sig_uv(4'h2), 100, 0))
        `CHK(seen2, exp_code(sig_uv(4'h0), 100, 0))
        bus(1'b0, `AMSS_REG_SEL, 32'h0000_0000, r);
        `CHK(r, 32'h0000_0002)
        for (int i = 1; i < 5; i++)
        begin
            bus(1'b0, i[3:0], 32'h0000_0000, r);
            `CHK(r, (i > 2) ? 32'h0000_0064 : 32'h0000_0000)
        end
        bus(1'b0, 4'hF, 32'h0000_0000, r);
        `CHK(r, 32'h0000_0000)
    endtask

    task automatic t_codes;
        for (int s = 0; s < 14; s++)
        begin
            if (s == 6)
                continue; // the reserved code is never programmed
            chk_sel(s[3:0]);
        end
        // flip every level input, then revisit the codes that show them
        @(posedge clk);
        pos_mode <= 1'b0;
        pos_done <= 1'b0;
        ref_done <= 1'b1;
        gain2 <= 1'b0;
        chk_sel(4'h3);
        chk_sel(4'h8);
        chk_sel(4'hB);
        chk_sel(4'hC);
    endtask

    task automatic t_scale;
        logic [31:0] r;
        bus(1'b1, `AMSS_REG_SEL, 32'h0000_0000, r);
        bus(1'b1, `AMSS_REG_GAIN1, 32'hFFFF_FF06, r);
        bus(1'b1, `AMSS_REG_OFS1, 32'h0000_000F, r);
        bus(1'b1, `AMSS_REG_GAIN2, 32'h0000_4E20, r);
        bus(1'b1, `AMSS_REG_OFS2, 32'hFFFF_FFEC, r);
        bus(1'b0, `AMSS_REG_GAIN1, 32'h0000_0000, r);
        `CHK(r, 32'hFFFF_FF06)
        bus(1'b0, `AMSS_REG_GAIN2, 32'h0000_0000, r);
        `CHK(r, 32'h0000_2710)
        repeat (7) @(posedge clk);
        `CHK(seen1, exp_code(sig_uv(4'h0), -250, 15))
        `CHK(seen2, exp_code(sig_uv(4'h0), 10000, -20))
        bus(1'b0, `AMSS_REG_STATUS, 32'h0000_0000, r);
        `CHK(r, 32'h0000_0001)
        q[0] <= -1000;
        repeat (8) @(posedge clk);
        `CHK(seen1, exp_code(sig_uv(4'h0), -250, 15))
        `CHK(seen2, 16'h7FFF)
        // position error outside position mode: only the offset is left, negated
        bus(1'b1, `AMSS_REG_SEL, 32'h0000_0303, r);
        repeat (7) @(posedge clk);
        `CHK(seen1, exp_code(sig_uv(4'h3), -250, 15))
        `CHK(seen2, exp_code(sig_uv(4'h3), 10000, -20))
    endtask

    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial
    begin
        q = '{1000, -500, 2000, 300, -1500, 5000, -2500, 10, -20, 100};
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_codes();
        t_scale();
        stop_test();
    end
endmodule

`default_nettype wire
